// ---- mcrb_cfg.svh ----
// Addresses, bit positions and reset values of the control register bank
`ifndef MCRB_CFG_SVH
`define MCRB_CFG_SVH

`define MCRB_ADDR_MISC       8'hC0
`define MCRB_ADDR_ANALOG     8'hC1
`define MCRB_ADDR_PWM_HIGH   8'hC6
`define MCRB_ADDR_PWM_LOW    8'hC7
`define MCRB_ADDR_PWM_EN     8'hC8

`define MCRB_RST_MISC        8'h80
`define MCRB_RST_ANALOG      8'h00
`define MCRB_RST_PWM_HIGH    8'h00
`define MCRB_RST_PWM_LOW     8'h80
`define MCRB_RST_PWM_EN      8'h00

`define MCRB_BIT_KEY         7
`define MCRB_BIT_CSYNC       6
`define MCRB_BIT_SEPSYNC     5
`define MCRB_BIT_DDC         4
`define MCRB_BIT_TWOWIRE     3
`define MCRB_BIT_ANALOG_COMPARE_ENABLE        2
`define MCRB_BIT_WINV        1
`define MCRB_BIT_NINV        0
`define MCRB_BIT_CHSEL       5
`define MCRB_BIT_COMP        0
`define MCRB_ANALOG_WMASK    8'h3E
`define MCRB_KEY_OFF         3'h5
`define MCRB_BITADDR_MISC    5'h18

`endif

// ---- mcrb_checker.sv ----
// Port-level assertions of the control register bank
`timescale 1ns/1ps
`include "mcrb_cfg.svh"
module mcrb_checker (
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    // Processor access and narrow PWM raw waveforms
    input wire logic [7:0]  sfr_addr_i,
    input wire logic [7:0]  sfr_wdata_i,
    input wire logic        sfr_wr_i,
    input wire logic [7:0]  bit_addr_i,
    input wire logic        bit_wr_i,
    input wire logic        bit_val_i,
    input wire logic [9:0]  narrow_pwm_raw_i,
    // Observed outputs
    input wire logic [9:0]  narrow_pwm_o,
    input wire logic        composite_sync_pin_select_o,
    input wire logic        separated_sync_pin_select_o,
    input wire logic        display_channel_pin_select_o,
    input wire logic        two_wire_pin_select_o,
    input wire logic        analog_compare_enable_o,
    input wire logic        compare_input_select_o,
    input wire logic [3:0]  reference_level_select_o,
    input wire logic [13:0] wide_pwm_value_o,
    input wire logic [7:0]  low_channel_output_enable_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire       wr_misc = sfr_wr_i && sfr_addr_i == `MCRB_ADDR_MISC;
    wire       wr_ana  = sfr_wr_i && sfr_addr_i == `MCRB_ADDR_ANALOG;
    wire [4:0] sel     = {composite_sync_pin_select_o, separated_sync_pin_select_o,
                          display_channel_pin_select_o, two_wire_pin_select_o,
                          analog_compare_enable_o};
    // Derived outputs follow a write two sampled edges later
    chk_pin_select_map: assert property (
        wr_misc |-> ##2 sel == $past(sfr_wdata_i[6:2], 2))
        else $error("pin selects do not follow misc write");
    chk_input_chan_sel: assert property (
        wr_ana |-> ##2 compare_input_select_o == $past(sfr_wdata_i[5], 2))
        else $error("input select does not follow analog write");
    chk_ref_level_sel: assert property (
        wr_ana |-> ##2 reference_level_select_o == $past(sfr_wdata_i[4:1], 2))
        else $error("reference level does not follow analog write");
    chk_pwm_en_copy: assert property (
        sfr_wr_i && sfr_addr_i == `MCRB_ADDR_PWM_EN
        |-> ##2 low_channel_output_enable_o == $past(sfr_wdata_i, 2))
        else $error("channel enables do not follow write");
    chk_wide_upper: assert property (
        sfr_wr_i && sfr_addr_i == `MCRB_ADDR_PWM_HIGH
        |-> ##2 wide_pwm_value_o[13:7] == $past(sfr_wdata_i[6:0], 2))
        else $error("wide value upper bits wrong");
    chk_wide_lower: assert property (
        sfr_wr_i && sfr_addr_i == `MCRB_ADDR_PWM_LOW
        |-> ##2 wide_pwm_value_o[6:0] == $past(sfr_wdata_i[6:0], 2))
        else $error("wide value lower bits wrong");
    chk_bit_write_sel: assert property (
        bit_wr_i && !sfr_wr_i && bit_addr_i == 8'hC6
        |-> ##2 composite_sync_pin_select_o == $past(bit_val_i, 2))
        else $error("bit write to misc bit 6 not applied");
    // All ten channels share one polarity, so they flip together or not at all
    chk_narrow_polarity: assert property (
        !$past(rst_i) |-> (narrow_pwm_o ^ $past(narrow_pwm_raw_i)) inside {10'h000, 10'h3FF})
        else $error("narrow channels not inverted together");
endmodule // mcrb_checker

bind mcrb_top mcrb_checker i_chk (.clk_sys_i, .rst_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i,
    .bit_addr_i, .bit_wr_i, .bit_val_i, .narrow_pwm_raw_i, .narrow_pwm_o,
    .composite_sync_pin_select_o, .separated_sync_pin_select_o, .display_channel_pin_select_o,
    .two_wire_pin_select_o, .analog_compare_enable_o, .compare_input_select_o,
    .reference_level_select_o, .wide_pwm_value_o, .low_channel_output_enable_o);

// ---- mcrb_pkg.sv ----
// Types shared by the control register bank modules
package mcrb_pkg;
    typedef logic [7:0] mcrb_byte_t;
    typedef logic [13:0] mcrb_wide_t;
endpackage

// ---- mcrb_reg_if.sv ----
// Carrier between the register store and its top
`timescale 1ns/1ps
interface mcrb_reg_if;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       wr_en;
    logic [7:0] misc;
    logic [7:0] analog;
    logic [7:0] pwm_high;
    logic [7:0] pwm_low;
    logic [7:0] pwm_en;
    logic       comp_sync;
    modport store (input wr_addr, wr_data, wr_en, comp_sync,
                   output misc, analog, pwm_high, pwm_low, pwm_en);
    modport ctrl (output wr_addr, wr_data, wr_en, comp_sync,
                  input misc, analog, pwm_high, pwm_low, pwm_en);
endinterface

// ---- mcrb_store.sv ----
// Register store of the control register bank
`timescale 1ns/1ps
`include "mcrb_cfg.svh"
module mcrb_store
    import mcrb_pkg::*;
(
    // Clock and reset
    input  wire logic   clk_sys_i,
    input  wire logic   rst_i,
    // Register carrier
    mcrb_reg_if.store   rif
);
    logic hit_misc;
    logic hit_analog;
    logic hit_high;
    logic hit_low;
    logic hit_en;
    assign hit_misc   = rif.wr_en && rif.wr_addr == `MCRB_ADDR_MISC;
    assign hit_analog = rif.wr_en && rif.wr_addr == `MCRB_ADDR_ANALOG;
    assign hit_high   = rif.wr_en && rif.wr_addr == `MCRB_ADDR_PWM_HIGH;
    assign hit_low    = rif.wr_en && rif.wr_addr == `MCRB_ADDR_PWM_LOW;
    assign hit_en     = rif.wr_en && rif.wr_addr == `MCRB_ADDR_PWM_EN;

    // Comparator bit is live status, reserved bits are never stored
    mcrb_byte_t next_analog;
    assign next_analog = (rif.wr_data & `MCRB_ANALOG_WMASK)
                       | {7'h00, rif.comp_sync}; // RQ17 RQ11

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rif.misc     <= `MCRB_RST_MISC; // RQ16
            rif.analog   <= `MCRB_RST_ANALOG;
            rif.pwm_high <= `MCRB_RST_PWM_HIGH;
            rif.pwm_low  <= `MCRB_RST_PWM_LOW;
            rif.pwm_en   <= `MCRB_RST_PWM_EN;
        end else begin
            if (hit_misc)
                rif.misc <= rif.wr_data;
            if (hit_analog)
                rif.analog <= next_analog;
            else
                rif.analog[`MCRB_BIT_COMP] <= rif.comp_sync; // RQ11
            if (hit_high)
                rif.pwm_high <= rif.wr_data;
            if (hit_low)
                rif.pwm_low <= rif.wr_data;
            if (hit_en)
                rif.pwm_en <= rif.wr_data;
        end
    end
endmodule // mcrb_store

// ---- mcrb_sync.sv ----
// Two-flop synchroniser for the comparator level
`timescale 1ns/1ps
module mcrb_sync (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    // Level
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // mcrb_sync

// ---- mcrb_top.sv ----
// Miscellaneous control register bank: pin selects, PWM polarity, ADC control
`timescale 1ns/1ps
`include "mcrb_cfg.svh"

// Behaviour
// [RQ1] Watchdog is disabled only when key bits 2,1,0 equal 101.
// [RQ2] Misc bit 6 routes the shared pin to composite sync, else port 1.6.
// [RQ3] Misc bit 5 drives separated sync outputs, else ports 1.4 and 1.5.
// [RQ4] Misc bit 4 connects display-channel clock/data, else ports 1.2 and 1.3.
// [RQ5] Misc bit 3 connects two-wire clock/data, else ports 1.0 and 1.1.
// [RQ6] Misc bit 2 enables comparator ADC and its two pins, else ports 3.2/3.3.
// [RQ7] Misc bit 1 inverts the wide PWM output.
// [RQ8] Misc bit 0 inverts all ten narrow PWM outputs.
// [RQ9] Analog bit 5 selects second input when one, first when zero.
// [RQ10] Analog bits 4..1 select the comparison reference level.
// [RQ11] Analog bit 0 reads the comparison result, read only.
// [RQ12] High latch bits 6..0 give wide PWM upper bits; bit 7 is a key bit.
// [RQ13] Low latch bits 6..0 give wide PWM lower bits; bit 7 is a key bit.
// [RQ14] Each misc register bit is separately bit addressable, plus byte access.
// [RQ15] Enable bit n switches PWM channel n onto its pin, else port 2.n.
// [RQ16] Misc register resets to 80h: port functions, non-inverted PWMs.
// [RQ17] Writes to comparison and reserved analog bits are ignored; reserved read 0.
// [RQ18] Wide PWM value is high seven bits above low seven bits.
module mcrb_top
    import mcrb_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // Processor byte access
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    output logic      [7:0]  sfr_rdata_o,
    // Processor bit access
    input  wire logic [7:0]  bit_addr_i,
    input  wire logic        bit_wr_i,
    input  wire logic        bit_val_i,
    output logic             bit_rdata_o,
    // PWM raw waveforms and comparator level
    input  wire logic [9:0]  narrow_pwm_raw_i,
    input  wire logic        wide_pwm_raw_i,
    input  wire logic        comp_raw_i,
    // Pin function and control outputs
    output logic             watchdog_disable_o,
    output logic             composite_sync_pin_select_o,
    output logic             separated_sync_pin_select_o,
    output logic             display_channel_pin_select_o,
    output logic             two_wire_pin_select_o,
    output logic             analog_compare_enable_o,
    output logic             compare_input_select_o,
    output logic      [3:0]  reference_level_select_o,
    output logic      [13:0] wide_pwm_value_o,
    output logic      [7:0]  low_channel_output_enable_o,
    output logic      [9:0]  narrow_pwm_o,
    output logic             wide_pwm_output_o
);
    ////////////////////////////////////////////////////////////////////////
    mcrb_reg_if rif ();
    logic comp_sync;

    mcrb_sync u_comp_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .d_i       (comp_raw_i),
        .q_o       (comp_sync)
    );

    // Bit writes to the misc register become a byte write with one bit changed
    logic       bit_hit;
    logic [2:0] bit_pos;
    mcrb_byte_t bit_merged;
    assign bit_hit    = bit_wr_i && bit_addr_i[7:3] == `MCRB_BITADDR_MISC; // RQ14
    assign bit_pos    = bit_addr_i[2:0];
    assign bit_merged = (rif.misc & ~(8'h01 << bit_pos))
                      | ({7'h00, bit_val_i} << bit_pos); // RQ14

    // Byte write wins if both arrive in one cycle
    assign rif.wr_en     = sfr_wr_i | bit_hit;
    assign rif.wr_addr   = sfr_wr_i ? sfr_addr_i : `MCRB_ADDR_MISC;
    assign rif.wr_data   = sfr_wr_i ? sfr_wdata_i : bit_merged;
    assign rif.comp_sync = comp_sync;

    mcrb_store u_store (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .rif       (rif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped addresses read zero
    mcrb_byte_t rd_mux;
    assign rd_mux = (sfr_addr_i == `MCRB_ADDR_MISC)     ? rif.misc     :
                    (sfr_addr_i == `MCRB_ADDR_ANALOG)   ? rif.analog   : // RQ17
                    (sfr_addr_i == `MCRB_ADDR_PWM_HIGH) ? rif.pwm_high :
                    (sfr_addr_i == `MCRB_ADDR_PWM_LOW)  ? rif.pwm_low  :
                    (sfr_addr_i == `MCRB_ADDR_PWM_EN)   ? rif.pwm_en   : 8'h00;

    logic       wdog_off;
    mcrb_wide_t wide_val;
    assign wdog_off = {rif.misc[`MCRB_BIT_KEY], rif.pwm_high[`MCRB_BIT_KEY],
                       rif.pwm_low[`MCRB_BIT_KEY]} == `MCRB_KEY_OFF; // RQ1
    assign wide_val = {rif.pwm_high[6:0], rif.pwm_low[6:0]}; // RQ12 RQ13 RQ18

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
            bit_rdata_o <= 1'b0;
        end else begin
            if (sfr_rd_i)
                sfr_rdata_o <= rd_mux;
            bit_rdata_o <= rif.misc[bit_pos]; // RQ14
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            watchdog_disable_o           <= 1'b0;
            composite_sync_pin_select_o  <= 1'b0;
            separated_sync_pin_select_o  <= 1'b0;
            display_channel_pin_select_o <= 1'b0;
            two_wire_pin_select_o        <= 1'b0;
            analog_compare_enable_o      <= 1'b0;
            compare_input_select_o       <= 1'b0;
            reference_level_select_o     <= 4'h0;
            wide_pwm_value_o             <= 14'h0000;
            low_channel_output_enable_o  <= 8'h00;
        end else begin
            watchdog_disable_o           <= wdog_off; // RQ1
            composite_sync_pin_select_o  <= rif.misc[`MCRB_BIT_CSYNC]; // RQ2
            separated_sync_pin_select_o  <= rif.misc[`MCRB_BIT_SEPSYNC]; // RQ3
            display_channel_pin_select_o <= rif.misc[`MCRB_BIT_DDC]; // RQ4
            two_wire_pin_select_o        <= rif.misc[`MCRB_BIT_TWOWIRE]; // RQ5
            analog_compare_enable_o      <= rif.misc[`MCRB_BIT_ANALOG_COMPARE_ENABLE]; // RQ6
            compare_input_select_o       <= rif.analog[`MCRB_BIT_CHSEL]; // RQ9
            reference_level_select_o     <= rif.analog[4:1]; // RQ10
            wide_pwm_value_o             <= wide_val; // RQ18
            low_channel_output_enable_o  <= rif.pwm_en; // RQ15
        end
    end

    // Polarity applied one flop late; adds one cycle of PWM delay
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            narrow_pwm_o      <= 10'h000;
            wide_pwm_output_o <= 1'b0;
        end else begin
            narrow_pwm_o      <= narrow_pwm_raw_i ^ {10{rif.misc[`MCRB_BIT_NINV]}}; // RQ8
            wide_pwm_output_o <= wide_pwm_raw_i ^ rif.misc[`MCRB_BIT_WINV]; // RQ7
        end
    end
endmodule // mcrb_top

// ---- testbench.sv ----
// Self-checking bench of the control register bank
`timescale 1ns/1ps
module testbench;
    import mcrb_pkg::*;
    typedef struct packed { mcrb_byte_t a; mcrb_byte_t d; mcrb_byte_t e; } mcrb_row_t;
    logic       clk_sys_i, rst_i, wr, rd, bwr, bval, brd, wraw, craw, wdog, chsel, wout;
    mcrb_byte_t addr, wdata, rdata, baddr, pen;
    logic [9:0] nraw, npwm;
    logic [4:0] sel;
    logic [3:0] refl;
    mcrb_wide_t wval;
    int         n_fail, n_checks;
    // Address, write data, expected read back (reserved and unmapped read zero)
    mcrb_row_t  rows [6] = '{'{8'hC0, 8'h7F, 8'h7F}, '{8'hC1, 8'hFF, 8'h3E},
        '{8'hC6, 8'hD5, 8'hD5}, '{8'hC7, 8'h2A, 8'h2A}, '{8'hC8, 8'hA5, 8'hA5},
        '{8'hC3, 8'h55, 8'h00}};
    mcrb_top i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sfr_addr_i(addr),
        .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata),
        .bit_addr_i(baddr), .bit_wr_i(bwr), .bit_val_i(bval), .bit_rdata_o(brd),
        .narrow_pwm_raw_i(nraw), .wide_pwm_raw_i(wraw), .comp_raw_i(craw),
        .watchdog_disable_o(wdog), .composite_sync_pin_select_o(sel[4]),
        .separated_sync_pin_select_o(sel[3]), .display_channel_pin_select_o(sel[2]),
        .two_wire_pin_select_o(sel[1]), .analog_compare_enable_o(sel[0]),
        .compare_input_select_o(chsel), .reference_level_select_o(refl),
        .wide_pwm_value_o(wval), .low_channel_output_enable_o(pen),
        .narrow_pwm_o(npwm), .wide_pwm_output_o(wout));
    always #10 clk_sys_i = ~clk_sys_i;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_byte(input mcrb_byte_t a, input mcrb_byte_t d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic wr_bit(input mcrb_byte_t a, input logic v);
        @(posedge clk_sys_i);
        baddr <= a;
        bval <= v;
        bwr <= 1'b1;
        @(posedge clk_sys_i);
        bwr <= 1'b0;
    endtask
    task automatic rd_byte(input mcrb_byte_t a, input mcrb_byte_t e);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 chk(rdata, e, "read data");
    endtask
    // Derived outputs lag the register by one edge; three edges leave margin
    task automatic settle;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_fail++;
        $display("[FAIL] %0t run did not finish", $time);
        stop_test;
    end
    initial begin
        {clk_sys_i, wr, rd, bwr, bval, wraw, craw, addr, wdata, baddr, nraw} = '0;
        rst_i = 1'b1;
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd_byte(8'hC0, 8'h80);
        rd_byte(8'hC7, 8'h80);
        chk(sel, 5'h00, "pins after reset");
        chk(wdog, 1'b1, "watchdog after reset");
        $display("test reset done");
        foreach (rows[i]) begin
            wr_byte(rows[i].a, rows[i].d);
            rd_byte(rows[i].a, rows[i].e);
        end
        settle;
        chk(sel, 5'h1F, "pin selects");
        chk(chsel, 1'b1, "input select");
        chk(refl, 4'hF, "reference level");
        chk(wval, {7'h55, 7'h2A}, "wide value");
        chk(pen, 8'hA5, "channel enables");
        $display("test register rows done");
        @(posedge clk_sys_i);
        nraw <= 10'h3A5;
        wraw <= 1'b1;
        settle;
        chk(npwm, 10'h05A, "narrow inverted");
        chk(wout, 1'b0, "wide inverted");
        wr_bit(8'hC0, 1'b0);
        wr_bit(8'hC1, 1'b0);
        wr_bit(8'hC6, 1'b0);
        settle;
        chk(npwm, 10'h3A5, "narrow plain");
        chk(wout, 1'b1, "wide plain");
        chk(sel, 5'h0F, "bit cleared");
        chk(brd, 1'b0, "bit read");
        @(posedge clk_sys_i);
        craw <= 1'b1;
        settle;
        rd_byte(8'hC1, 8'h3F);
        $display("test polarity and bits done");
        for (int k = 0; k < 8; k++) begin
            wr_byte(8'hC0, {k[2], 7'h7F});
            wr_byte(8'hC6, {k[1], 7'h55});
            wr_byte(8'hC7, {k[0], 7'h2A});
            settle;
            chk(wdog, k == 5, "watchdog key");
        end
        $display("test watchdog key done");
        stop_test;
    end
endmodule // testbench
